// >>> design/sio3_defines.svh
// Register map, field positions, reset values and timing counts of the serial port
`ifndef SIO3_DEFINES_SVH
`define SIO3_DEFINES_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define SIO_OFS_CTRL    8'h00
`define SIO_OFS_STATUS  8'h04
`define SIO_OFS_SHIFT   8'h08
`define SIO_OFS_RXDATA  8'h0c
// ****************************************
// Control register fields
// ****************************************
`define SIO_CTRL_CKSEL_LO  0
`define SIO_CTRL_CKSEL_HI  1
`define SIO_CTRL_SO_EN     2
`define SIO_CTRL_START     3
`define SIO_CTRL_CK_DIR    4
`define SIO_CTRL_SO_DIR    5
`define SIO_CTRL_SI_DIR    6
`define SIO_CTRL_CK_LAT    8
`define SIO_CTRL_SO_LAT    9
`define SIO_CTRL_SI_LAT    10
// ****************************************
// Status register fields
// ****************************************
`define SIO_STAT_BUSY      4
`define SIO_STAT_RXVALID   5
`define SIO_STAT_FULL      6
`define SIO_STAT_PINS      8
// ****************************************
// Counts and reset values
// ****************************************
`define SIO_BITS_PER_XFER  4'h8
`define SIO_HALF_SEL1      8'h10
`define SIO_HALF_SEL2      8'h20
`define SIO_HALF_SEL3      8'h40
`define SIO_RST_SHIFT      8'h00
`endif

// >>> design/sio3_pkg.sv
// Types shared by the three-wire serial port
package sio3_pkg;
  // Transfer sequencing: waiting or shifting
  typedef enum logic {
    ST_WAIT,
    ST_RUN
  } xfer_state_t;
  // Clock source of the port
  typedef enum logic {
    MODE_SLAVE,
    MODE_MASTER
  } clk_mode_t;
endpackage

// >>> design/sio3_port.sv
// Three-wire serial port with AHB-Lite registers and a receive FIFO
//
// Function
// - Both clock-select bits zero pick slave on the external clock, else master.
// - Slave waiting: clock pin floats with direction 0, drives its latch with 1.
// - Slave running: clock pin floats taking the clock with 0, drives latch with 1.
// - Master waiting: clock pin floats with direction 0, drives high with 1.
// - Master running: clock pin drives the internal clock with 1, floats with 0.
// - Output pin floats with 0; with 1 it carries data if enabled, else its latch.
// - Input pin floats and takes data with 0, drives its latch with 1.
// - The clock counter counts each falling shift-clock edge while running.
// - With output enabled the MSB goes out on each falling edge; else none.
// - Each rising edge shifts the input pin level into the LSB, any direction.
// - Writing 1 to the start flag leaves the wait state and starts shifting if the FIFO has room.
// - The rising edge with the counter at 8 clears the start flag and waits.
// - Writing 0 to the start flag while running forces wait and zeroes the counter.
// - While waiting the clock logic and the shift register stand still.
`timescale 1ns/10ps
`default_nettype none
`include "sio3_defines.svh"

// ****************************************
// Receive FIFO
// ****************************************
module sio3_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  // Extra pointer bit tells full from empty
  assign empty = (wr_ptr == rd_ptr);
  assign full  = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
                 (wr_ptr[AW] != rd_ptr[AW]);
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rd_ptr[AW-1:0]];

  // Storage write
  always_ff @(posedge i_clk_sys) begin
    if (i_in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (i_in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (i_out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ****************************************
// Serial port top
// ****************************************
module sio3_port
  import sio3_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic      [31:0] o_hrdata,
  // Shift clock pin
  input  wire logic        i_sck,
  output logic             o_sck_out,
  output logic             o_sck_oe_n,
  // Serial out pin
  input  wire logic        i_so,
  output logic             o_so_out,
  output logic             o_so_oe_n,
  // Serial in pin
  input  wire logic        i_si,
  output logic             o_si_out,
  output logic             o_si_oe_n
);
  // Control fields
  logic        clock_select_low;
  logic        clock_select_high;
  logic        serial_output_enable;
  logic        clock_pin_direction;
  logic        output_pin_direction;
  logic        input_pin_direction;
  logic [2:0]  pin_latch;
  xfer_state_t state;
  clk_mode_t   mode;
  // Shift path
  logic [7:0]  presettable_shift_register;
  logic [3:0]  clk_count;
  logic        so_bit;
  // Pin synchronisers, first stage read only by the second
  logic [2:0]  pin_s1;
  logic [2:0]  pin_s2;
  logic        sck_s3;
  // Internal clock generator
  logic [7:0]  half_cnt;
  logic [7:0]  half_len;
  logic        sck_int;
  // Bus pipeline
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        acc;
  logic [31:0] next_rdata;
  logic        ctrl_wr;
  logic        start_req;
  logic        force_req;
  logic        rx_pop;
  // Edge events and completion
  logic        fall_ev;
  logic        rise_ev;
  logic        done;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pin_s1 <= 3'h7;
      pin_s2 <= 3'h7;
      sck_s3 <= 1'b1;
    end else begin
      pin_s1 <= {i_sck, i_so, i_si};
      pin_s2 <= pin_s1;
      sck_s3 <= pin_s2[2];
    end
  end

  // ****************************************
  // Mode and edge events
  // ****************************************
  // clock source select
  assign mode = (clock_select_high || clock_select_low) ? MODE_MASTER
                                                        : MODE_SLAVE;
  always_comb begin
    case ({clock_select_high, clock_select_low})
      2'b01:   half_len = `SIO_HALF_SEL1;
      2'b10:   half_len = `SIO_HALF_SEL2;
      default: half_len = `SIO_HALF_SEL3;
    endcase
  end

  always_comb begin
    fall_ev = 1'b0;
    rise_ev = 1'b0;
    if (state == ST_RUN) begin
      if (mode == MODE_MASTER) begin
        fall_ev = (half_cnt == half_len - 8'h01) && sck_int;
        rise_ev = (half_cnt == half_len - 8'h01) && !sck_int;
      end else begin
        fall_ev = sck_s3 && !pin_s2[2];
        rise_ev = !sck_s3 && pin_s2[2];
      end
    end
  end
  // eighth rising edge ends the transfer
  assign done = rise_ev && (clk_count == `SIO_BITS_PER_XFER);

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign acc       = i_hsel && i_htrans[1] && i_hready;
  assign ctrl_wr   = wr_pend && (wr_addr == `SIO_OFS_CTRL);
  // Start is held off while the FIFO has no room for the result
  assign start_req = ctrl_wr && i_hwdata[`SIO_CTRL_START] &&
                     (state == ST_WAIT) && fifo_in_ready;
  assign force_req = ctrl_wr && !i_hwdata[`SIO_CTRL_START] &&
                     (state == ST_RUN);
  assign rx_pop    = acc && !i_hwrite &&
                     (i_haddr[7:0] == `SIO_OFS_RXDATA);

  // Write address phase is kept for the data phase
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc && i_hwrite;
      wr_addr <= i_haddr[7:0];
    end
  end

  // Read data captured at the address phase; unmapped reads return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_haddr[7:0])
      `SIO_OFS_CTRL: begin
        next_rdata[`SIO_CTRL_CKSEL_LO] = clock_select_low;
        next_rdata[`SIO_CTRL_CKSEL_HI] = clock_select_high;
        next_rdata[`SIO_CTRL_SO_EN]    = serial_output_enable;
        next_rdata[`SIO_CTRL_START]    = (state == ST_RUN);
        next_rdata[`SIO_CTRL_CK_DIR]   = clock_pin_direction;
        next_rdata[`SIO_CTRL_SO_DIR]   = output_pin_direction;
        next_rdata[`SIO_CTRL_SI_DIR]   = input_pin_direction;
        next_rdata[`SIO_CTRL_SI_LAT+:1] = pin_latch[0];
        next_rdata[`SIO_CTRL_SO_LAT+:1] = pin_latch[1];
        next_rdata[`SIO_CTRL_CK_LAT+:1] = pin_latch[2];
      end
      `SIO_OFS_STATUS: begin
        next_rdata[3:0]                = clk_count;
        next_rdata[`SIO_STAT_BUSY]     = (state == ST_RUN);
        next_rdata[`SIO_STAT_RXVALID]  = fifo_out_valid;
        next_rdata[`SIO_STAT_FULL]     = !fifo_in_ready;
        next_rdata[`SIO_STAT_PINS+:3]  = pin_s2;
      end
      `SIO_OFS_SHIFT:  next_rdata[7:0] = presettable_shift_register;
      `SIO_OFS_RXDATA: next_rdata[7:0] = fifo_out_data;
      default:         next_rdata      = 32'h0000_0000;
    endcase
  end

  // Zero wait states, always OKAY
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (acc && !i_hwrite) begin
        o_hrdata <= next_rdata;
      end
    end
  end

  // Control fields other than the start flag
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      clock_select_low     <= 1'b0;
      clock_select_high    <= 1'b0;
      serial_output_enable <= 1'b0;
      clock_pin_direction  <= 1'b0;
      output_pin_direction <= 1'b0;
      input_pin_direction  <= 1'b0;
      pin_latch            <= 3'h0;
    end else if (ctrl_wr) begin
      clock_select_low     <= i_hwdata[`SIO_CTRL_CKSEL_LO];
      clock_select_high    <= i_hwdata[`SIO_CTRL_CKSEL_HI];
      serial_output_enable <= i_hwdata[`SIO_CTRL_SO_EN];
      clock_pin_direction  <= i_hwdata[`SIO_CTRL_CK_DIR];
      output_pin_direction <= i_hwdata[`SIO_CTRL_SO_DIR];
      input_pin_direction  <= i_hwdata[`SIO_CTRL_SI_DIR];
      pin_latch <= {i_hwdata[`SIO_CTRL_CK_LAT], i_hwdata[`SIO_CTRL_SO_LAT],
                    i_hwdata[`SIO_CTRL_SI_LAT]};
    end
  end

  // ****************************************
  // Wait control and clock counter
  // ****************************************
  // Transfer-start flag is the run state itself
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= ST_WAIT;
    end else if (start_req) begin
      state <= ST_RUN;
    end else if (force_req || done) begin
      state <= ST_WAIT;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      clk_count <= 4'h0;
    end else if (start_req || force_req) begin
      clk_count <= 4'h0;
    end else if (fall_ev) begin
      clk_count <= clk_count + 4'h1;
    end
  end

  // Internal clock idles high, stops when waiting
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      half_cnt <= 8'h00;
      sck_int  <= 1'b1;
    end else if (state != ST_RUN || mode != MODE_MASTER || done) begin
      half_cnt <= 8'h00;
      sck_int  <= 1'b1;
    end else if (half_cnt == half_len - 8'h01) begin
      half_cnt <= 8'h00;
      sck_int  <= !sck_int;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  // ****************************************
  // Shift register
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      presettable_shift_register <= `SIO_RST_SHIFT;
    end else if (rise_ev) begin
      presettable_shift_register <= {presettable_shift_register[6:0],
                                     pin_s2[0]};
    end else if (wr_pend && wr_addr == `SIO_OFS_SHIFT &&
                 state == ST_WAIT) begin
      // software load in the wait state only
      presettable_shift_register <= i_hwdata[7:0];
    end
  end

  // MSB presented on the falling edge
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      so_bit <= 1'b0;
    end else if (fall_ev) begin
      so_bit <= presettable_shift_register[7];
    end
  end

  // Finished byte enters the FIFO; room was checked at start
  sio3_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_in_valid  (done),
    .i_in_data   ({presettable_shift_register[6:0], pin_s2[0]}),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (rx_pop)
  );

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_sck_out  <= 1'b1;
      o_sck_oe_n <= 1'b1;
      o_so_out   <= 1'b0;
      o_so_oe_n  <= 1'b1;
      o_si_out   <= 1'b0;
      o_si_oe_n  <= 1'b1;
    end else begin
      o_sck_oe_n <= !clock_pin_direction;
      if (mode == MODE_SLAVE) begin
        o_sck_out <= pin_latch[2];
      end else begin
        o_sck_out <= (state == ST_RUN) ? sck_int : 1'b1;
      end
      o_so_oe_n <= !output_pin_direction;
      o_so_out  <= serial_output_enable ? so_bit : pin_latch[1];
      o_si_oe_n <= !input_pin_direction;
      o_si_out  <= pin_latch[0];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_end_xfer;
    done |=> state == ST_WAIT && fifo_out_valid;
  endproperty
  a_end_xfer: assert property (p_end_xfer) else $error("no wait after 8");
  property p_count;
    fall_ev && !force_req |=> clk_count == $past(clk_count) + 4'h1;
  endproperty
  a_count: assert property (p_count) else $error("counter missed edge");
  property p_force;
    force_req |=> state == ST_WAIT && clk_count == 4'h0;
  endproperty
  a_force: assert property (p_force) else $error("forced wait failed");
  property p_start;
    start_req |=> state == ST_RUN && clk_count == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_shift_in;
    rise_ev |=> presettable_shift_register[0] == $past(pin_s2[0]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("LSB not captured");
  property p_shift_out;
    fall_ev ##1 (serial_output_enable && output_pin_direction) |=>
      o_so_out == $past(so_bit) && !o_so_oe_n;
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("MSB not out");
  property p_master_wait;
    mode == MODE_MASTER && state == ST_WAIT && clock_pin_direction
      |=> o_sck_out && !o_sck_oe_n;
  endproperty
  a_master_wait: assert property (p_master_wait) else $error("sck not high");
  property p_slave_pin;
    mode == MODE_SLAVE && clock_pin_direction |=> o_sck_out == $past(pin_latch[2]);
  endproperty
  a_slave_pin: assert property (p_slave_pin) else $error("sck latch wrong");
  property p_halt;
    state == ST_WAIT && !start_req |=> $stable(clk_count) && !fall_ev;
  endproperty
  a_halt: assert property (p_halt) else $error("logic ran in wait");
  property p_si_pin;
    !input_pin_direction |=> o_si_oe_n;
  endproperty
  a_si_pin: assert property (p_si_pin) else $error("input pin driven");
endmodule
`default_nettype wire

// >>> tb/sio3_peer.sv
// Far-side serial peer: clocks in slave mode, shifts data both ways
`timescale 1ns/10ps
`default_nettype none

module sio3_peer (
  // Line levels seen at the pins
  input  wire logic i_sck,
  input  wire logic i_so,
  // Peer drives
  output logic      o_sck,
  output logic      o_sck_en,
  output logic      o_si
);
  logic [7:0] tx;
  logic [7:0] rx;

  // Idle clock stands high, nothing latched yet
  initial begin
    o_sck    = 1'b1;
    o_sck_en = 1'b0;
    o_si     = 1'b0;
    tx       = 8'h00;
    rx       = 8'h00;
  end

  // Next bit MSB first; the vacated bit is inverted so that a stale
  // level after the frame never passes for data
  // peer mirrors order
  always @(negedge i_sck) begin
    o_si = tx[7];
    tx   = {tx[6:0], ~tx[7]};
  end

  // Sample late in the high phase: the synchronised output lags the pin
  // data on rising edge
  always @(posedge i_sck) begin
    #90;
    rx = {rx[6:0], i_so};
  end

  // Slave-mode clock, 200 ns period, driven only within the frame
  task automatic clocks(input int n);
    #7;
    o_sck_en = 1'b1;
    repeat (n) begin
      o_sck = 1'b0;
      #100;
      o_sck = 1'b1;
      #100;
    end
    o_sck_en = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/three_wire_serial_io_modes_tb.sv
// Self-checking bench for the three-wire serial port
`timescale 1ns/10ps
`default_nettype none
`include "sio3_defines.svh"

module three_wire_serial_io_modes_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic        i_clk_sys = 1'b0;
  logic        i_rst     = 1'b1;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp;
  logic        sck_out, sck_oe_n, so_out, so_oe_n, si_out, si_oe_n;
  logic        p_sck, p_sck_en, p_si;
  logic [7:0]  q[$];
  int          n_errors    = 0;
  int          checks_done = 0;
  // Clock line has a pull-up; a floating output shows no stale level
  wire         sck_w = !sck_oe_n ? sck_out : (p_sck_en ? p_sck : 1'b1);
  wire         so_w  = so_oe_n ? ~so_out : so_out;
  wire         si_w  = si_oe_n ? p_si : si_out;

  always #12.5 i_clk_sys = ~i_clk_sys;

  sio3_port dut (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_hsel      (hsel),
    .i_haddr     (haddr),
    .i_htrans    (htrans),
    .i_hwrite    (hwrite),
    .i_hsize     (3'b010),
    .i_hwdata    (hwdata),
    .i_hready    (hreadyout),
    .o_hreadyout (hreadyout),
    .o_hresp     (hresp),
    .o_hrdata    (hrdata),
    .i_sck       (sck_w),
    .o_sck_out   (sck_out),
    .o_sck_oe_n  (sck_oe_n),
    .i_so        (so_w),
    .o_so_out    (so_out),
    .o_so_oe_n   (so_oe_n),
    .i_si        (si_w),
    .o_si_out    (si_out),
    .o_si_oe_n   (si_oe_n)
  );

  sio3_peer peer (
    .i_sck    (sck_w),
    .i_so     (so_w),
    .o_sck    (p_sck),
    .o_sck_en (p_sck_en),
    .o_si     (p_si)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task print_verdict;
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic expire(input string m);
    n_errors++;
    $display("Error %0t: wait expired at %s", $time, m);
    print_verdict;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (hreadyout !== 1'b1) expire("bus ready");
  endtask

  // One single word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    // Align to a rising edge: the peer's clock bursts end off the edge
    @(posedge i_clk_sys);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] t;
    ahb(1'b1, a, v, t);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    ahb(1'b0, a, 32'h0, v);
  endtask

  // Control word from clock select, flags {si,so,ck dir,start,so en}, latches
  function automatic logic [31:0] ctl(input logic [1:0] sel,
                                     input logic [6:2] f,
                                     input logic [2:0] lat);
    ctl = {21'h0, lat, 1'b0, f, sel};
  endfunction

  // Full byte exchange; the received byte is queued for the drain check
  task automatic xfer(input logic [31:0] c, input logic [7:0] tx, rxb);
    logic [31:0] d;
    logic [7:0]  exp_rx;
    int          k;
    wreg(`SIO_OFS_SHIFT, {24'h0, tx});
    peer.tx = rxb;
    peer.rx = 8'h00;
    wreg(`SIO_OFS_CTRL, c | 32'h8);
    repeat (3) @(posedge i_clk_sys);
    check(sck_oe_n, !c[4], "clock pin drive while running");
    if (c[1:0] == 2'b00) begin
      // Load attempt while busy must not disturb the frame
      wreg(`SIO_OFS_SHIFT, {24'h0, ~tx});
      peer.clocks(8);
    end
    k = 0;
    do begin
      rreg(`SIO_OFS_CTRL, d);
      k++;
    end while (d[3] !== 1'b0 && k < 2000);
    check(d[3], 1'b0, "start flag cleared");
    if (d[3] !== 1'b0) expire("transfer end");
    repeat (4) @(posedge i_clk_sys);
    if (c[5]) check(peer.rx, c[2] ? tx : {8{c[9]}}, "serial out");
    exp_rx = c[6] ? {8{c[10]}} : rxb;
    rreg(`SIO_OFS_SHIFT, d);
    check(d[7:0], exp_rx, "shift in");
    q.push_back(exp_rx);
    check({so_oe_n, si_oe_n}, {~c[5], ~c[6]}, "data pins");
    if (c[1:0] != 2'b00) check({sck_out, sck_oe_n}, 2'b10, "idle");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [31:0] r;
    void'($urandom(83));
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    check({hreadyout, hresp, sck_oe_n, so_oe_n, si_oe_n, sck_out}, 6'h2f,
          "reset levels");
    wreg(8'h20, 32'hffffffff);
    rreg(8'h20, d);
    check(d, 32'h0, "unmapped read");
    // Latch high, so the hand-over to the peer's low clock is a real fall
    wreg(`SIO_OFS_CTRL, ctl(2'b00, 5'b00100, 3'b001));
    repeat (2) @(posedge i_clk_sys);
    check({sck_out, sck_oe_n}, 2'b10, "slave wait latch");
    // Forced wait part-way through a slave frame
    wreg(`SIO_OFS_CTRL, ctl(2'b00, 5'b00010, 3'b000));
    peer.clocks(3);
    rreg(`SIO_OFS_STATUS, d);
    check(d[4:0], 5'h13, "count three");
    wreg(`SIO_OFS_CTRL, 32'h0);
    peer.clocks(2);
    rreg(`SIO_OFS_STATUS, d);
    check(d[4:0], 5'h00, "forced wait");
    // Every clock mode in turn; the first four drive data out
    for (int i = 0; i < 32; i++) begin
      r = $urandom;
      if (i < 4) r[2:0] = 3'b101;
      xfer(ctl(i[1:0], {r[1], r[0], i[1:0] != 2'b00, 1'b0, r[2]}, r[5:3]),
           r[15:8], r[23:16]);
    end
    // Full FIFO holds the port back
    rreg(`SIO_OFS_STATUS, d);
    check(d[6:5], 2'b11, "fifo full");
    wreg(`SIO_OFS_CTRL, 32'h19);
    rreg(`SIO_OFS_CTRL, d);
    check(d[3], 1'b0, "start refused");
    for (int i = 0; i < 32; i++) begin
      rreg(`SIO_OFS_RXDATA, d);
      check(d[7:0], q.pop_front(), "fifo order");
    end
    rreg(`SIO_OFS_STATUS, d);
    check(d[6:5], 2'b00, "fifo empty");
    print_verdict;
  end
endmodule
`default_nettype wire
